//--- include/spi_seq_pkg.sv
// Purpose: shared constants and types of the serial transfer sequencer
// Assumes: one frame width, fixed FIFO depth
// Notes: mode codes match the transfer direction field
`default_nettype none
package spi_seq_pkg;
  localparam int FRAME_W = 8;
  localparam int DEPTH = 256;
  localparam int PTR_W = 8;
  localparam int CNT_W = 9;
  localparam int TARGETS = 4;
  localparam int DIV_W = 16;
  localparam logic [DIV_W-1:0] MIN_HALF = 16'h0003; // shortest half period in clocks
  localparam int ENABLE_BIT = 0;
  localparam logic [1:0] MODE_TX_RX = 2'h0;
  localparam logic [1:0] MODE_TX_ONLY = 2'h1;
  localparam logic [1:0] MODE_RX_ONLY = 2'h2;
  localparam logic [FRAME_W-1:0] FRAME_RESET = 8'h00;
  localparam logic [CNT_W-1:0] FIFO_FULL = 9'h100;
  localparam logic [3:0] LAST_EDGE = 4'hF;
  localparam logic [2:0] LAST_BIT = 3'h7;
  typedef struct packed {
    logic [1:0] transfer_direction_mode;
    logic serial_clock_polarity;
    logic serial_clock_phase;
    logic three_wire;
    logic sequential;
    logic master_writes;
  } frame_control_type;
  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_SHIFT = 2'b01,
    M_NEXT = 2'b10
  } master_state_type;
endpackage
`default_nettype wire

//--- hdl/spi_seq.sv
// Purpose: transfer sequencing of a master/slave synchronous serial port
// Assumes: control inputs held steady while enabled; 8-bit frames
// Notes: slave link logic runs on the external serial clock
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - master starts: target selected, transmit data present
// - no target selected keeps transfer pending
// - frame count holds frames minus one
// - transmitting master stops on empty transmit FIFO
// - receive-only master stops after counted frames
// - busy high during transfer, low after
// - mode codes: 0 both, 1 tx, 2 rx
// - receive-only slave resends held transmit word
// - slave starts only on external select
// - slave ends on select removal, clears busy
// - three-wire sequential read stops after counted frames
// - slave treats control frame as plain data
// - disabled slave ignores its select
// - each FIFO holds 256 entries
// - enable bit 0 turns controller on
// - target-select bit n drives select output n
// - clock polarity and phase match far device
// - transmit-empty and receive-full service requests
// - data writes push, data reads pop
module spi_seq
  import spi_seq_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // configuration
  input wire logic [7:0] controller_enable_i,
  input wire logic master_mode_i,
  input wire frame_control_type frame_control_i,
  input wire logic [15:0] receive_frame_count_i,
  input wire logic [DIV_W-1:0] bit_rate_divider_i,
  input wire logic [PTR_W-1:0] tx_fifo_threshold_i,
  input wire logic [PTR_W-1:0] rx_fifo_threshold_i,
  input wire logic [TARGETS-1:0] target_select_i,
  // data port
  input wire logic tx_write_i,
  input wire logic [FRAME_W-1:0] tx_data_i,
  output logic tx_ready_o,
  input wire logic rx_read_i,
  output logic [FRAME_W-1:0] rx_data_o,
  output logic rx_valid_o,
  // status and service requests
  output logic busy_o,
  output logic tx_empty_req_o,
  output logic rx_full_req_o,
  // master pins
  output logic sclk_o,
  output logic mosi_o,
  output logic [TARGETS-1:0] target_select_n_o,
  input wire logic miso_i,
  // slave pins
  input wire logic slave_sclk_i,
  input wire logic slave_select_n_i,
  input wire logic slave_rx_i,
  output logic slave_tx_o,
  output logic slave_tx_oe_o
);
  logic enabled;
  logic [1:0] mode;
  assign enabled = controller_enable_i[ENABLE_BIT];
  assign mode = frame_control_i.transfer_direction_mode;

  // both FIFOs are plain arrays with pointer pairs
  logic [FRAME_W-1:0] tx_mem [DEPTH];
  logic [FRAME_W-1:0] rx_mem [DEPTH];
  logic [PTR_W-1:0] tx_wp_reg, tx_rp_reg, rx_wp_reg, rx_rp_reg;
  logic [PTR_W-1:0] tx_wp_next, tx_rp_next, rx_wp_next, rx_rp_next;
  logic [CNT_W-1:0] tx_cnt_reg, rx_cnt_reg, tx_cnt_next, rx_cnt_next;
  logic [FRAME_W-1:0] rx_data_reg, rx_data_next, push_word;
  logic tx_push, tx_pop, rx_push, rx_pop, m_pop, m_push, s_pop, s_push;
  logic [FRAME_W-1:0] tx_head;

  assign tx_head = tx_mem[tx_rp_reg];
  assign tx_push = tx_write_i && (tx_cnt_reg != FIFO_FULL);
  assign rx_pop = rx_read_i && (rx_cnt_reg != '0);
  assign tx_pop = m_pop || s_pop;
  assign rx_push = (m_push || s_push) && (rx_cnt_reg != FIFO_FULL); // overflow drops the word

  // pointer and fill arithmetic
  always_comb begin
    tx_wp_next = tx_wp_reg + PTR_W'(tx_push);
    tx_rp_next = tx_rp_reg + PTR_W'(tx_pop);
    rx_wp_next = rx_wp_reg + PTR_W'(rx_push);
    rx_rp_next = rx_rp_reg + PTR_W'(rx_pop);
    tx_cnt_next = tx_cnt_reg + CNT_W'(tx_push) - CNT_W'(tx_pop);
    rx_cnt_next = rx_cnt_reg + CNT_W'(rx_push) - CNT_W'(rx_pop);
    rx_data_next = rx_pop ? rx_mem[rx_rp_reg] : rx_data_reg;
  end

  always_ff @(posedge clk_i) begin
    if (tx_push) begin
      tx_mem[tx_wp_reg] <= tx_data_i;
    end
    if (rx_push) begin
      rx_mem[rx_wp_reg] <= push_word;
    end
    if (reset_i) begin
      tx_wp_reg <= '0;
      tx_rp_reg <= '0;
      rx_wp_reg <= '0;
      rx_rp_reg <= '0;
      tx_cnt_reg <= '0;
      rx_cnt_reg <= '0;
      rx_data_reg <= FRAME_RESET;
    end else begin
      tx_wp_reg <= tx_wp_next;
      tx_rp_reg <= tx_rp_next;
      rx_wp_reg <= rx_wp_next;
      rx_rp_reg <= rx_rp_next;
      tx_cnt_reg <= tx_cnt_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_data_reg <= rx_data_next;
    end
  end

  assign tx_ready_o = tx_cnt_reg != FIFO_FULL;
  assign rx_valid_o = rx_cnt_reg != '0;
  assign rx_data_o = rx_data_reg;
  // service requests follow the fill levels against thresholds
  assign tx_empty_req_o = enabled && (tx_cnt_reg <= CNT_W'(tx_fifo_threshold_i));
  assign rx_full_req_o = enabled && (rx_cnt_reg > CNT_W'(rx_fifo_threshold_i));

  // pin synchronisers: only the second stage is read
  logic miso_s1_reg, miso_s2_reg, seln_s1_reg, seln_s2_reg;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      miso_s1_reg <= 1'b0;
      miso_s2_reg <= 1'b0;
      seln_s1_reg <= 1'b1;
      seln_s2_reg <= 1'b1;
    end else begin
      miso_s1_reg <= miso_i;
      miso_s2_reg <= miso_s1_reg;
      seln_s1_reg <= slave_select_n_i;
      seln_s2_reg <= seln_s1_reg;
    end
  end

  // master sequencer, serial clock divided from clk_i
  master_state_type m_state_reg, m_state_next;
  logic [DIV_W-1:0] half_reg, half_next, half_lim;
  logic [3:0] edge_reg, edge_next;
  logic [FRAME_W-1:0] mtx_reg, mtx_next, mrx_reg, mrx_next;
  logic [15:0] fcnt_reg, fcnt_next;
  logic first_reg, first_next, sclk_reg, sclk_next, start_ok, counting, counted, store;
  logic [TARGETS-1:0] ssn_reg, ssn_next;

  // the two input synchroniser stages eat two clocks of each half period,
  // so a shorter half period would sample the bit before the wanted one
  assign half_lim = (DIV_W'(bit_rate_divider_i[DIV_W-1:1]) < MIN_HALF) ? MIN_HALF
                    : DIV_W'(bit_rate_divider_i[DIV_W-1:1]);
  assign start_ok = enabled && master_mode_i && (target_select_i != '0) && (tx_cnt_reg != '0);
  assign counting = (mode == MODE_RX_ONLY) || (frame_control_i.three_wire && frame_control_i.sequential
                    && !frame_control_i.master_writes);
  assign counted = counting && !(frame_control_i.three_wire && first_reg);
  // the control frame of a three-wire transfer carries no read data
  assign store = (mode != MODE_TX_ONLY) && !(frame_control_i.three_wire && (frame_control_i.master_writes || first_reg));

  always_comb begin
    m_state_next = m_state_reg;
    half_next = half_reg;
    edge_next = edge_reg;
    mtx_next = mtx_reg;
    mrx_next = mrx_reg;
    fcnt_next = fcnt_reg;
    first_next = first_reg;
    sclk_next = sclk_reg;
    m_pop = 1'b0;
    m_push = 1'b0;
    case (m_state_reg)
      M_IDLE: begin
        sclk_next = frame_control_i.serial_clock_polarity;
        if (start_ok) begin
          m_pop = 1'b1;
          mtx_next = tx_head;
          half_next = '0;
          edge_next = '0;
          fcnt_next = '0;
          first_next = 1'b1;
          m_state_next = M_SHIFT;
        end
      end
      M_SHIFT: begin
        if (half_reg == half_lim - DIV_W'(1)) begin
          half_next = '0;
          sclk_next = ~sclk_reg;
          edge_next = edge_reg + 4'h1;
          // phase picks which edge samples and which shifts
          if (edge_reg[0] == frame_control_i.serial_clock_phase) begin
            mrx_next = {mrx_reg[FRAME_W-2:0], miso_s2_reg};
          end else if (edge_reg != '0) begin
            mtx_next = {mtx_reg[FRAME_W-2:0], 1'b0};
          end
          if (edge_reg == LAST_EDGE) begin
            m_state_next = M_NEXT;
          end
        end else begin
          half_next = half_reg + DIV_W'(1);
        end
      end
      M_NEXT: begin
        m_push = store;
        first_next = 1'b0;
        half_next = '0;
        edge_next = '0;
        if (counted) begin
          fcnt_next = fcnt_reg + 16'h1;
        end
        if (counted && (fcnt_reg == receive_frame_count_i)) begin
          m_state_next = M_IDLE;
        end else if (counting) begin
          m_state_next = M_SHIFT; // reads go on without fresh transmit data
        end else if (tx_cnt_reg != '0) begin
          m_pop = 1'b1;
          mtx_next = tx_head;
          m_state_next = M_SHIFT;
        end else begin
          m_state_next = M_IDLE;
        end
      end
      default: m_state_next = M_IDLE;
    endcase
    if (!enabled || !master_mode_i) begin
      m_state_next = M_IDLE;
      m_pop = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      m_state_reg <= M_IDLE;
      half_reg <= '0;
      edge_reg <= '0;
      mtx_reg <= FRAME_RESET;
      mrx_reg <= FRAME_RESET;
      fcnt_reg <= '0;
      first_reg <= 1'b0;
      sclk_reg <= 1'b0;
      ssn_reg <= '1;
    end else begin
      m_state_reg <= m_state_next;
      half_reg <= half_next;
      edge_reg <= edge_next;
      mtx_reg <= mtx_next;
      mrx_reg <= mrx_next;
      fcnt_reg <= fcnt_next;
      first_reg <= first_next;
      sclk_reg <= sclk_next;
      ssn_reg <= ssn_next;
    end
  end

  // one select output per target-select bit
  generate
    for (genvar t = 0; t < TARGETS; t++) begin : g_sel
      assign ssn_next[t] = ~(target_select_i[t] && (m_state_next != M_IDLE));
    end
  endgenerate

  assign sclk_o = sclk_reg;
  assign mosi_o = mtx_reg[FRAME_W-1];
  assign target_select_n_o = ssn_reg;

  // slave link domain; select removal clears the frame state
  logic slave_clk, l_first_reg, l_tgl_reg;
  logic [2:0] l_bit_reg, l_out_reg;
  logic [FRAME_W-1:0] l_sh_reg, l_word_reg, l_txw_reg, s_hold_reg;
  assign slave_clk = slave_sclk_i ^ frame_control_i.serial_clock_polarity ^ frame_control_i.serial_clock_phase;

  always_ff @(posedge slave_clk or posedge slave_select_n_i) begin
    if (slave_select_n_i) begin
      l_bit_reg <= '0;
      l_sh_reg <= FRAME_RESET;
      l_first_reg <= 1'b1;
      l_txw_reg <= FRAME_RESET;
    end else begin
      l_bit_reg <= l_bit_reg + 3'h1;
      l_sh_reg <= {l_sh_reg[FRAME_W-2:0], slave_rx_i};
      if (l_bit_reg == LAST_BIT) begin
        l_first_reg <= 1'b0;
        l_txw_reg <= s_hold_reg; // hold word stable long before this edge
      end
    end
  end

  // finished words and their toggle survive the end of frame
  always_ff @(posedge slave_clk or posedge reset_i) begin
    if (reset_i) begin
      l_tgl_reg <= 1'b0;
      l_word_reg <= FRAME_RESET;
    end else if (!slave_select_n_i && (l_bit_reg == LAST_BIT)) begin
      l_tgl_reg <= ~l_tgl_reg;
      l_word_reg <= {l_sh_reg[FRAME_W-2:0], slave_rx_i};
    end
  end

  always_ff @(negedge slave_clk or posedge slave_select_n_i) begin
    if (slave_select_n_i) begin
      l_out_reg <= LAST_BIT;
    end else begin
      l_out_reg <= l_out_reg - 3'h1;
    end
  end

  assign slave_tx_o = l_first_reg ? s_hold_reg[l_out_reg] : l_txw_reg[l_out_reg];
  assign slave_tx_oe_o = enabled && !master_mode_i && !slave_select_n_i;

  // system side of the slave: word toggle crossing and transmit prefetch
  logic tg1_reg, tg2_reg, tg3_reg, hold_ok_reg, hold_ok_next, slave_on;
  logic [FRAME_W-1:0] s_hold_next;
  assign slave_on = enabled && !master_mode_i;
  assign s_push = slave_on && (tg2_reg != tg3_reg) && (mode != MODE_TX_ONLY);
  assign s_pop = slave_on && !hold_ok_reg && (tx_cnt_reg != '0) && (mode != MODE_RX_ONLY);
  assign push_word = master_mode_i ? mrx_next : l_word_reg;

  always_comb begin
    hold_ok_next = hold_ok_reg;
    s_hold_next = s_hold_reg;
    if (tg2_reg != tg3_reg) begin
      hold_ok_next = 1'b0;
    end else if (s_pop) begin
      s_hold_next = tx_head;
      hold_ok_next = 1'b1;
    end
    if (mode == MODE_RX_ONLY) begin
      hold_ok_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tg1_reg <= 1'b0;
      tg2_reg <= 1'b0;
      tg3_reg <= 1'b0;
      hold_ok_reg <= 1'b0;
      s_hold_reg <= FRAME_RESET;
    end else begin
      tg1_reg <= l_tgl_reg;
      tg2_reg <= tg1_reg;
      tg3_reg <= tg2_reg;
      hold_ok_reg <= hold_ok_next;
      s_hold_reg <= s_hold_next;
    end
  end

  assign busy_o = master_mode_i ? (m_state_reg != M_IDLE) : (slave_on && !seln_s2_reg);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  start_go_a: assert property (m_state_reg == M_IDLE && start_ok |=> busy_o)
    else $error("master did not start");
  pend_a: assert property (master_mode_i && m_state_reg == M_IDLE && target_select_i == '0 |=> !busy_o)
    else $error("started without target");
  tx_end_a: assert property (m_state_reg == M_NEXT && !counting && tx_cnt_reg == '0 && enabled |=> !busy_o)
    else $error("no stop on empty fifo");
  rx_end_a: assert property (m_state_reg == M_NEXT && counted && fcnt_reg == receive_frame_count_i
    |=> m_state_reg == M_IDLE)
    else $error("no stop after frame count");
  busy_flag_a: assert property (master_mode_i && !busy_o |-> target_select_n_o == '1)
    else $error("select low while not busy");
  slave_off_a: assert property (!slave_on |-> !slave_tx_oe_o && !s_push)
    else $error("disabled slave responded");
  select_map_a: assert property (
    target_select_n_o == ~({TARGETS{m_state_reg != M_IDLE}} & $past(target_select_i)))
    else $error("select output mismatch");
  tx_full_a: assert property (tx_write_i && tx_cnt_reg == FIFO_FULL && !tx_pop |=> $stable(tx_cnt_reg))
    else $error("write past full fifo");
  rx_pop_a: assert property (rx_pop && !rx_push |=> rx_cnt_reg == $past(rx_cnt_reg) - CNT_W'(1))
    else $error("read did not pop");
  slave_end_a: assert property (!master_mode_i && seln_s2_reg |-> !busy_o)
    else $error("slave busy after deselect");
  master_done_c: cover property (m_state_reg == M_NEXT ##1 m_state_reg == M_IDLE);
  rx_only_c: cover property (mode == MODE_RX_ONLY && m_state_reg == M_NEXT && counted && fcnt_reg != '0);
  slave_word_c: cover property (s_push ##[1:40] s_pop);
endmodule // spi_seq
`default_nettype wire

//--- sim/far_slave.sv
// Purpose: far-end serial slave on select output 0
// Assumes: clock idles low, data sampled on rising edge
// Notes: line is not held once deselected
`timescale 1ns/1ps
`default_nettype none
module far_slave (
  // link pins
  input wire logic sclk_i,
  input wire logic sel_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  // test side
  input wire logic [7:0] reply_i,
  output logic [7:0] got_o
);
  logic [7:0] sh_reg;
  initial begin
    miso_o = 1'h0;
    got_o = 8'h00;
  end
  // load the reply as soon as selected
  always @(negedge sel_n_i) begin
    sh_reg = reply_i;
    miso_o = reply_i[7];
  end
  // mode 0 only, the master must match it
  always @(posedge sclk_i) begin
    if (!sel_n_i) got_o = {got_o[6:0], mosi_i};
  end
  // rotate so the reply repeats every frame
  always @(negedge sclk_i) begin
    if (!sel_n_i) begin
      sh_reg = {sh_reg[6:0], sh_reg[7]};
      miso_o = sh_reg[7];
    end
  end
  // no pull on the line: show the inverse so stale data never matches
  always @(posedge sel_n_i) miso_o = ~miso_o;
endmodule // far_slave
`default_nettype wire

//--- sim/spi_transfer_sequencing_tb.sv
// Purpose: self-checking bench of the transfer sequencer
// Assumes: divider 4, one far slave on select output 0
// Notes: slave link clock runs only inside frames
`timescale 1ns/1ps
`default_nettype none
module spi_transfer_sequencing_tb;
  import spi_seq_pkg::*;
  logic clk_i, reset_i, mm, txw, rxr, ssel_n, sclk_s, srx, miso;
  logic txr, rxv, busy, te, rf, sclk, mosi, stx, soe;
  logic [7:0] en, txd, rxd, reply, got;
  logic [3:0] ts, tsn;
  logic [15:0] rfc;
  frame_control_type fc;
  int err_total, n_compared, cyc;
  spi_seq u_dut (.clk_i(clk_i), .reset_i(reset_i), .controller_enable_i(en), .master_mode_i(mm),
    .frame_control_i(fc), .receive_frame_count_i(rfc), .bit_rate_divider_i(16'h0004),
    .tx_fifo_threshold_i(8'h00), .rx_fifo_threshold_i(8'h01), .target_select_i(ts),
    .tx_write_i(txw), .tx_data_i(txd), .tx_ready_o(txr), .rx_read_i(rxr), .rx_data_o(rxd),
    .rx_valid_o(rxv), .busy_o(busy), .tx_empty_req_o(te), .rx_full_req_o(rf), .sclk_o(sclk),
    .mosi_o(mosi), .target_select_n_o(tsn), .miso_i(miso), .slave_sclk_i(sclk_s),
    .slave_select_n_i(ssel_n), .slave_rx_i(srx), .slave_tx_o(stx), .slave_tx_oe_o(soe));
  // one slave on the first select output
  far_slave u_far (.sclk_i(sclk), .sel_n_i(tsn[0]), .mosi_i(mosi), .miso_o(miso),
    .reply_i(reply), .got_o(got));
  // 40 MHz system clock
  initial begin
    clk_i = 1'h0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic chk(string what, logic [15:0] exp, logic [15:0] seen);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wait_busy(logic lvl, int lim);
    for (int k = 0; k < lim && busy !== lvl; k++) begin
      @(posedge clk_i);
      #1;
    end
  endtask
  task automatic push(logic [7:0] b);
    @(posedge clk_i);
    txw <= 1'h1;
    txd <= b;
    @(posedge clk_i);
    txw <= 1'h0;
  endtask
  // pop until empty; each word must equal w
  task automatic drain(int m, logic [7:0] w);
    int k;
    k = 0;
    #1;
    while (rxv === 1'h1 && k < 300) begin
      @(posedge clk_i);
      rxr <= 1'h1;
      @(posedge clk_i);
      rxr <= 1'h0;
      #1;
      chk("rx word", w, rxd);
      k++;
    end
    chk("rx count", m, k);
  endtask
  task automatic do_reset;
    reset_i <= 1'h1;
    repeat (16) @(posedge clk_i);
    reset_i <= 1'h0;
    @(posedge clk_i);
    #1;
    chk("rst busy", 0, busy);
    chk("rst select", 4'hF, tsn);
    chk("rst ready", 1, txr);
  endtask
  // master run: queue words with no target, then select target 0 plus random others
  task automatic xfer(logic [1:0] md, logic tw, int n, logic [15:0] cnt);
    int m;
    logic [7:0] w;
    logic [2:0] r3;
    m = (md == MODE_TX_ONLY) ? 0 : ((md == MODE_RX_ONLY || tw) ? cnt + 1 : n);
    @(posedge clk_i);
    en <= 8'h00;
    mm <= 1'h1;
    ts <= 4'h0;
    fc <= '{md, 1'h0, 1'h0, tw, tw, 1'h0};
    rfc <= cnt;
    reply <= $urandom;
    @(posedge clk_i);
    en <= 8'h01;
    for (int i = 0; i < n; i++) begin
      w = $urandom;
      push(w);
    end
    repeat (40) @(posedge clk_i);
    #1;
    chk("pending busy", 0, busy);
    chk("tx empty req", 0, te);
    r3 = $urandom;
    @(posedge clk_i);
    ts <= {r3, 1'h1};
    wait_busy(1'h1, 20);
    chk("start busy", 1, busy);
    chk("select", ts ^ 4'hF, tsn);
    wait_busy(1'h0, 1600);
    chk("end busy", 0, busy);
    chk("tx empty req", 1, te);
    chk("rx full req", m > 1, rf);
    if (md != MODE_RX_ONLY && !tw) chk("far got", w, got);
    drain(m, reply);
  endtask
  // slave frame driven in the far master's place
  task automatic slave(logic [1:0] md, logic on, logic [7:0] b, logic [7:0] wt, logic [7:0] exp);
    logic [7:0] cap;
    @(posedge clk_i);
    en <= 8'h00;
    mm <= 1'h0;
    fc <= '{md, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0};
    @(posedge clk_i);
    en <= {7'h00, on};
    if (on && md != MODE_RX_ONLY) push(wt);
    #100 ssel_n = 1'h0;
    cap = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      srx = b[i];
      #40 sclk_s = 1'h1;
      cap = {cap[6:0], stx};
      #40 sclk_s = 1'h0;
    end
    repeat (8) @(posedge clk_i);
    #1;
    chk("slave busy", on, busy);
    chk("slave oe", on, soe);
    ssel_n = 1'h1;
    srx = ~srx;
    repeat (8) @(posedge clk_i);
    #1;
    chk("slave idle", 0, busy);
    if (on) chk("slave out", exp, cap);
    drain(on && md != MODE_TX_ONLY, b);
  endtask
  // hang guard
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop;
    end
  end
  initial begin
    int k;
    logic [7:0] w1, w2;
    {reset_i, mm, txw, rxr, srx, sclk_s, ssel_n} = 7'h41;
    {en, txd, reply, ts, rfc, fc} = '0;
    {err_total, n_compared, cyc} = '0;
    void'($urandom(32'h58E0CE04));
    do_reset();
    for (int md = 0; md < 3; md++) begin
      xfer(md[1:0], 1'h0, (md == 2) ? 1 : 1 + $urandom % 4, $urandom % 4);
    end
    xfer(MODE_RX_ONLY, 1'h0, 1, 16'h0000);
    xfer(MODE_TX_RX, 1'h0, 4, 16'h0000);
    xfer(MODE_TX_RX, 1'h1, 1, 16'h0002);
    // fill with no target until refused
    @(posedge clk_i);
    ts <= 4'h0;
    txw <= 1'h1;
    k = 0;
    repeat (DEPTH + 4) begin
      @(negedge clk_i);
      if (txr === 1'h1) k++;
    end
    @(posedge clk_i);
    txw <= 1'h0;
    chk("fill count", DEPTH, k);
    chk("full ready", 0, txr);
    do_reset();
    w1 = $urandom;
    w2 = $urandom;
    slave(MODE_TX_RX, 1'h0, $urandom, w1, w1);
    slave(MODE_TX_RX, 1'h1, $urandom, w1, w1);
    slave(MODE_TX_ONLY, 1'h1, $urandom, w2, w2);
    slave(MODE_RX_ONLY, 1'h1, $urandom, w1, w2);
    report_and_stop();
  end
endmodule // spi_transfer_sequencing_tb
`default_nettype wire
